// File: src/boe_pkg.sv
// Purpose: shared constants and types for the byte operation execution unit
// Assumes: 16-bit program words, 8-bit data, 12-bit data space
// Notes: register offsets are byte addresses on the Avalon-MM slave
package boe_pkg;
  localparam int unsigned PC_W = 21;
  localparam int unsigned FA_W = 12;
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BANK = 8'h04;
  localparam logic [7:0] REG_ACC = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_PC = 8'h10;
  localparam logic [7:0] REG_INDEX = 8'h14;
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_EXT = 1;
  // status bit positions
  localparam int unsigned ST_C = 0;
  localparam int unsigned ST_DC = 1;
  localparam int unsigned ST_Z = 2;
  localparam int unsigned ST_OV = 3;
  localparam int unsigned ST_N = 4;
  localparam logic [4:0] STATUS_RST = 5'h00;
  localparam logic [PC_W-1:0] PC_RST = 21'h00_0000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h00_0002;
  localparam logic [15:0] NOP_WORD = 16'h0000;
  // opcodes (upper six or eight bits of the first word)
  localparam logic [5:0] OPC_DEC_SKIP_Z = 6'h0B;
  localparam logic [5:0] OPC_DEC_SKIP_NZ = 6'h13;
  localparam logic [5:0] OPC_INC = 6'h0A;
  localparam logic [5:0] OPC_FILE_SUB = 6'h17;
  localparam logic [7:0] OPC_LIT_SUB = 8'h08;
  localparam logic [7:0] OPC_BRANCH = 8'hEF;
  // access bank split: addresses at or below 95 sit in the low half
  localparam logic [7:0] ACCESS_SPLIT = 8'h5F;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} boe_phase_e;

  typedef struct packed {
    logic [FA_W-1:0] addr;
    logic [7:0] wdata;
    logic we;
  } boe_file_req_s;

  typedef struct packed {
    logic [7:0] sum;
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } boe_alu_s;
endpackage : boe_pkg

// File: src/boe_exec_unit.sv
// Purpose: executes decrement-skip, increment, both subtracts and the long branch
// Assumes: program and file memories answer combinationally within one clock
// Notes: one instruction cycle is four clocks, Q1 to Q4; next word fetched at Q4
// What this block does
// - decrement-skip-zero: file minus one goes to accumulator (d=0) or file (d=1)
// - long branch loads 20-bit target, low byte then upper twelve, into pc 20:1
// - long branch takes two cycles; second cycle does nothing but load pc
// - increment: file plus one goes to accumulator or back to file
// - increment sets C, DC, N, OV, Z; decrement-skips touch no flags
// - access bit 0 with extended set and address at most 95 uses indexed offset
// - literal subtract: literal minus accumulator into accumulator, all five flags
// - file subtract: file minus accumulator routed by destination bit
// - subtracts set carry without borrow, zero on zero, negative on negative
// - access bit 0 picks access bank, 1 picks bank select pointer bank
`timescale 1ns/1ps
`default_nettype none
module boe_exec_unit
  import boe_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [PC_W-1:0] prog_addr,
  input wire logic [15:0] prog_rdata,
  output boe_file_req_s file_req,
  input wire logic [7:0] file_rdata
);
  boe_phase_e phase_reg;
  logic run_reg, ext_reg, ack_reg, flush_reg, goto2_reg;
  logic [3:0] bank_reg;
  logic [FA_W-1:0] idx_reg;
  logic [7:0] w_reg, fdata_reg, absolute_long_branch_lo_reg;
  logic [4:0] status_reg;
  logic [PC_W-1:0] pc_reg;
  logic [15:0] ir_reg;
  boe_alu_s alu_next, alu_reg;
  logic is_dsz, is_dsnz, is_dec, is_inc, is_fsub, is_lsub, is_sub, is_absolute_long_branch, is_fop;
  logic exec, halted, bus_wr, dest_file;
  logic [7:0] sub_minuend;

  function automatic boe_alu_s alu_add(input logic [7:0] a, input logic [7:0] b,
                                       input logic cin);
    logic [8:0] s;
    logic [4:0] lo;
    boe_alu_s r;
    s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    r.sum = s[7:0];
    r.c = s[8];
    r.dc = lo[4];
    r.z = (s[7:0] == 8'h00);
    r.n = s[7];
    r.ov = (a[7] == b[7]) && (s[7] != a[7]);
    return r;
  endfunction : alu_add

  function automatic logic [FA_W-1:0] file_addr(input logic [7:0] f, input logic acc,
                                                input logic ext, input logic [3:0] bank,
                                                input logic [FA_W-1:0] idx);
    if (acc) begin
      file_addr = {bank, f};
    end else if (ext && f <= ACCESS_SPLIT) begin
      file_addr = idx + {4'h0, f};
    end else if (f <= ACCESS_SPLIT) begin
      file_addr = {4'h0, f};
    end else begin
      file_addr = {ACCESS_HIGH_BANK, f};
    end
  endfunction : file_addr

  // decode of the word in the instruction register
  assign is_dsz = (ir_reg[15:10] == OPC_DEC_SKIP_Z);
  assign is_dsnz = (ir_reg[15:10] == OPC_DEC_SKIP_NZ);
  assign is_dec = is_dsz || is_dsnz;
  assign is_inc = (ir_reg[15:10] == OPC_INC);
  assign is_fsub = (ir_reg[15:10] == OPC_FILE_SUB);
  assign is_lsub = (ir_reg[15:8] == OPC_LIT_SUB);
  assign is_sub = is_fsub || is_lsub;
  assign is_absolute_long_branch = (ir_reg[15:8] == OPC_BRANCH);
  assign is_fop = is_dec || is_inc || is_fsub;
  assign dest_file = ir_reg[9];
  // a discarded word, or the second word of a branch, executes as no operation
  assign exec = !flush_reg && !goto2_reg;
  // a pending no-op cycle of a skip or branch still runs, so a halt never splits one
  assign halted = !run_reg && exec && (phase_reg == PH_Q1);
  assign bus_wr = write && ack_reg;
  assign sub_minuend = is_lsub ? ir_reg[7:0] : fdata_reg;

  always_comb begin
    if (is_sub) begin
      alu_next = alu_add(sub_minuend, ~w_reg, 1'b1);
    end else if (is_inc) begin
      alu_next = alu_add(fdata_reg, 8'h00, 1'b1);
    end else if (is_dec) begin
      alu_next = alu_add(fdata_reg, 8'hFF, 1'b0);
    end else begin
      alu_next = alu_add(fdata_reg, 8'h00, 1'b0);
    end
  end

  // bus slave: one wait state, answer on the second cycle of a request
  assign waitrequest = (read || write) && !ack_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      readdata <= 32'h0000_0000;
    end else begin
      ack_reg <= (read || write) && !ack_reg;
      if (read && !ack_reg) begin
        if (address == REG_CTRL) begin
          readdata <= {30'h0000_0000, ext_reg, run_reg};
        end else if (address == REG_BANK) begin
          readdata <= {28'h000_0000, bank_reg};
        end else if (address == REG_ACC) begin
          readdata <= {24'h00_0000, w_reg};
        end else if (address == REG_STATUS) begin
          readdata <= {27'h000_0000, status_reg};
        end else if (address == REG_PC) begin
          readdata <= {11'h000, pc_reg};
        end else if (address == REG_INDEX) begin
          readdata <= {20'h0_0000, idx_reg};
        end else begin
          readdata <= 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= 1'b0;
      ext_reg <= 1'b0;
      bank_reg <= 4'h0;
      idx_reg <= 12'h000;
    end else if (bus_wr) begin
      if (address == REG_CTRL) begin
        run_reg <= writedata[CTRL_RUN];
        ext_reg <= writedata[CTRL_EXT];
      end else if (address == REG_BANK) begin
        bank_reg <= writedata[3:0];
      end else if (address == REG_INDEX) begin
        idx_reg <= writedata[FA_W-1:0];
      end
    end
  end

  // phase sequencer: a started instruction cycle always runs to Q4
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= PH_Q1;
    end else begin
      case (phase_reg)
        PH_Q1: begin
          if (run_reg || !exec) begin
            phase_reg <= PH_Q2;
          end
        end
        PH_Q2: phase_reg <= PH_Q3;
        PH_Q3: phase_reg <= PH_Q4;
        default: phase_reg <= PH_Q1;
      endcase
    end
  end

  // file port: address at Q1, read captured at Q2, write strobe stands in Q4
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      file_req <= '0;
      fdata_reg <= 8'h00;
      alu_reg <= '0;
    end else begin
      case (phase_reg)
        PH_Q1: file_req.addr <= file_addr(ir_reg[7:0], ir_reg[8], ext_reg, bank_reg, idx_reg);
        PH_Q2: fdata_reg <= file_rdata;
        PH_Q3: begin
          alu_reg <= alu_next;
          file_req.wdata <= alu_next.sum;
          file_req.we <= exec && is_fop && dest_file;
        end
        default: file_req.we <= 1'b0;
      endcase
    end
  end

  // accumulator and flags: core at Q4, software only while halted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_reg <= 8'h00;
      status_reg <= STATUS_RST;
    end else if (phase_reg == PH_Q4 && exec) begin
      if (is_lsub || (is_fop && !dest_file)) begin
        w_reg <= alu_reg.sum;
      end
      if (is_inc || is_sub) begin
        status_reg <= {alu_reg.n, alu_reg.ov, alu_reg.z, alu_reg.dc, alu_reg.c};
      end
    end else if (bus_wr && halted && address == REG_ACC) begin
      w_reg <= writedata[7:0];
    end else if (bus_wr && halted && address == REG_STATUS) begin
      status_reg <= writedata[4:0];
    end
  end

  // fetch, skip and long branch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_reg <= PC_RST;
      prog_addr <= PC_RST;
      ir_reg <= NOP_WORD;
      flush_reg <= 1'b0;
      goto2_reg <= 1'b0;
      absolute_long_branch_lo_reg <= 8'h00;
    end else if (bus_wr && halted && address == REG_PC) begin
      pc_reg <= {writedata[PC_W-1:1], 1'b0};
      ir_reg <= NOP_WORD;
      flush_reg <= 1'b0;
      goto2_reg <= 1'b0;
    end else if (phase_reg == PH_Q3) begin
      if (goto2_reg) begin
        prog_addr <= {ir_reg[11:0], absolute_long_branch_lo_reg, 1'b0};
      end else begin
        prog_addr <= pc_reg;
      end
    end else if (phase_reg == PH_Q4) begin
      ir_reg <= prog_rdata;
      pc_reg <= prog_addr + PC_STEP;
      // a skipped two-word branch leaves its second word, which runs as a no-op
      flush_reg <= exec && ((is_dsz && alu_reg.z) || (is_dsnz && !alu_reg.z));
      goto2_reg <= exec && is_absolute_long_branch;
      if (exec && is_absolute_long_branch) begin
        absolute_long_branch_lo_reg <= ir_reg[7:0];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_branch_first;
    phase_reg == PH_Q4 && exec && is_absolute_long_branch;
  endsequence
  sequence s_branch_second;
    (goto2_reg && !file_req.we) [*4] ##1 !goto2_reg;
  endsequence

  a_dec_to_acc: assert property ((phase_reg == PH_Q4 && exec && is_dec && !dest_file)
    |=> w_reg == fdata_reg - 8'h01) else $error("decrement result missing in acc");
  a_dec_to_file: assert property ((phase_reg == PH_Q3 && exec && is_dec && dest_file)
    |=> file_req.we && file_req.wdata == fdata_reg - 8'h01)
    else $error("decrement result not written back");
  a_skip_zero: assert property ((phase_reg == PH_Q4 && exec && is_dsz && alu_reg.z)
    |=> flush_reg [*4] ##1 !flush_reg) else $error("zero skip did not discard");
  a_skip_nonzero: assert property ((phase_reg == PH_Q4 && exec && is_dsnz)
    |=> flush_reg == !$past(alu_reg.z)) else $error("nonzero skip wrong");
  a_branch_target: assert property ((phase_reg == PH_Q4 && goto2_reg)
    |-> prog_addr == {ir_reg[11:0], absolute_long_branch_lo_reg, 1'b0})
    else $error("branch target wrong");
  a_branch_cycles: assert property (s_branch_first |=> s_branch_second)
    else $error("branch second cycle wrong");
  a_inc_result: assert property ((phase_reg == PH_Q4 && exec && is_inc && !dest_file)
    |=> w_reg == fdata_reg + 8'h01) else $error("increment result wrong");
  a_inc_flags: assert property ((phase_reg == PH_Q4 && exec && is_inc)
    |=> status_reg[ST_Z] == (fdata_reg == 8'hFF) && status_reg[ST_C] == (fdata_reg == 8'hFF))
    else $error("increment flags wrong");
  a_dec_flags_hold: assert property ((phase_reg == PH_Q4 && exec && is_dec)
    |=> $stable(status_reg)) else $error("decrement changed flags");
  a_index_addr: assert property ((phase_reg == PH_Q1 && !ir_reg[8] && ext_reg
    && ir_reg[7:0] <= ACCESS_SPLIT)
    |=> file_req.addr == $past(idx_reg) + {4'h0, $past(ir_reg[7:0])})
    else $error("indexed address wrong");
  a_bank_addr: assert property ((phase_reg == PH_Q1 && ir_reg[8])
    |=> file_req.addr == {$past(bank_reg), $past(ir_reg[7:0])})
    else $error("bank address wrong");
  a_lit_sub: assert property ((phase_reg == PH_Q4 && exec && is_lsub)
    |=> w_reg == $past(ir_reg[7:0]) - $past(w_reg)) else $error("literal subtract wrong");
  a_file_sub: assert property ((phase_reg == PH_Q3 && exec && is_fsub)
    |=> alu_reg.sum == fdata_reg - w_reg) else $error("file subtract wrong");
  a_sub_flags: assert property ((phase_reg == PH_Q4 && exec && is_sub)
    |=> status_reg[ST_C] == ($past(sub_minuend) >= $past(w_reg))
    && status_reg[ST_Z] == ($past(sub_minuend) == $past(w_reg))
    && status_reg[ST_N] == $past(alu_reg.sum[7])) else $error("subtract flags wrong");
endmodule : boe_exec_unit
`default_nettype wire

// File: verif/boe_mem_model.sv
// Purpose: program memory and data file memory facing the execution unit
// Assumes: both memories answer combinationally; file writes land on the clock edge while we is high
// Notes: program space is 4096 words, byte address bits above 12 wrap
`timescale 1ns/1ps
`default_nettype none
module boe_mem_model
  import boe_pkg::*;
(
  input wire logic clk,
  input wire logic [PC_W-1:0] prog_addr,
  output logic [15:0] prog_rdata,
  input wire boe_file_req_s file_req,
  output logic [7:0] file_rdata
);
  logic [15:0] prog [0:4095];
  logic [7:0] fmem [0:4095];
  initial begin
    for (int i = 0; i < 4096; i++) begin
      fmem[i] = 8'h00;
      prog[i] = NOP_WORD;
    end
  end
  assign prog_rdata = prog[prog_addr[12:1]];
  assign file_rdata = fmem[file_req.addr];
  always @(posedge clk) begin
    if (file_req.we) begin
      fmem[file_req.addr] <= file_req.wdata;
    end
  end
endmodule : boe_mem_model
`default_nettype wire

// File: verif/boe_exec_unit_tb.sv
// Purpose: self-checking bench for the execution unit
// Assumes: core halted after reset; registers reached over Avalon-MM
// Notes: each program ends in a long branch to itself, then the core is halted
`timescale 1ns/1ps
`default_nettype none
module boe_exec_unit_tb;
  import boe_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic waitrequest;
  logic [PC_W-1:0] prog_addr;
  logic [15:0] prog_rdata;
  boe_file_req_s file_req;
  logic [7:0] file_rdata;
  logic [31:0] q;
  int n_errors = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  boe_exec_unit DUT (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .prog_addr(prog_addr), .prog_rdata(prog_rdata), .file_req(file_req),
    .file_rdata(file_rdata));
  boe_mem_model mem (.clk(clk), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
    .file_req(file_req), .file_rdata(file_rdata));
  task automatic stop_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // one access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      n_errors++;
      stop_test();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  function automatic logic [15:0] fop(input logic [5:0] op, input logic d, input logic a,
    input logic [7:0] f);
    return {op, d, a, f};
  endfunction : fop
  task automatic load;
    for (int i = 0; i < 4096; i++) begin
      mem.prog[i] = NOP_WORD;
    end
  endtask : load
  task automatic absolute_long_branch_at(input int w, input logic [19:0] k);
    mem.prog[w] = {8'hEF, k[7:0]};
    mem.prog[w + 1] = {4'hF, k[19:8]};
  endtask : absolute_long_branch_at
  // start at pc 0, wait for the closing loop, optionally poke ACC while running, halt
  task automatic run_prog(input int loop_w, input logic ext, input logic poke);
    int i;
    bus(1'b1, REG_PC, 32'h0000_0000);
    bus(1'b1, REG_CTRL, {30'h0000_0000, ext, 1'b1});
    for (i = 0; i < 400; i++) begin
      @(posedge clk);
      if (prog_addr === PC_W'(2 * loop_w)) break;
    end
    if (i == 400) begin
      n_errors++;
      stop_test();
    end
    repeat (40) @(posedge clk);
    if (poke) begin
      bus(1'b1, REG_ACC, 32'h0000_00AA);
    end
    bus(1'b1, REG_CTRL, 32'h0000_0000);
    repeat (8) @(posedge clk);
  endtask : run_prog
  // skip on zero, skip on nonzero over a two-word branch, far branch target
  task automatic t_skip;
    load();
    mem.fmem[12'h020] = 8'h01;
    mem.fmem[12'h340] = 8'h05;
    mem.prog[0] = fop(OPC_DEC_SKIP_Z, 1'b1, 1'b0, 8'h20);
    mem.prog[1] = fop(OPC_INC, 1'b1, 1'b0, 8'h20);
    mem.prog[2] = fop(OPC_DEC_SKIP_NZ, 1'b0, 1'b1, 8'h40);
    absolute_long_branch_at(3, 20'h0_0000);
    absolute_long_branch_at(5, 20'h0_0105);
    absolute_long_branch_at(32'h0105, 20'h0_0105);
    bus(1'b1, REG_BANK, 32'h0000_0003);
    bus(1'b1, REG_STATUS, 32'h0000_0015);
    run_prog(32'h0105, 1'b0, 1'b1);
    chk("skip_z file", {24'h00_0000, mem.fmem[12'h020]}, 32'h0000_0000);
    chk("skip_nz file", {24'h00_0000, mem.fmem[12'h340]}, 32'h0000_0005);
    bus(1'b0, REG_ACC, 32'h0000_0000);
    chk("skip_nz acc", q, 32'h0000_0004);
    bus(1'b0, REG_STATUS, 32'h0000_0000);
    chk("skip status", q, 32'h0000_0015);
  endtask : t_skip
  // increment through a banked file and through indexed offset addressing
  task automatic t_inc;
    load();
    mem.fmem[12'h380] = 8'h41;
    mem.fmem[12'h210] = 8'hFF;
    mem.fmem[12'h010] = 8'h77;
    mem.fmem[12'hF90] = 8'h10;
    mem.prog[0] = fop(OPC_INC, 1'b1, 1'b1, 8'h80);
    mem.prog[1] = fop(OPC_INC, 1'b1, 1'b0, 8'h90);
    mem.prog[2] = fop(OPC_INC, 1'b0, 1'b0, 8'h10);
    absolute_long_branch_at(3, 20'h0_0003);
    bus(1'b1, REG_BANK, 32'h0000_0003);
    bus(1'b1, REG_INDEX, 32'h0000_0200);
    bus(1'b1, REG_ACC, 32'h0000_0033);
    run_prog(3, 1'b1, 1'b0);
    chk("inc bank file", {24'h00_0000, mem.fmem[12'h380]}, 32'h0000_0042);
    chk("inc access high", {24'h00_0000, mem.fmem[12'hF90]}, 32'h0000_0011);
    chk("inc index file", {24'h00_0000, mem.fmem[12'h210]}, 32'h0000_00FF);
    bus(1'b0, REG_ACC, 32'h0000_0000);
    chk("inc acc", q, 32'h0000_0000);
    bus(1'b0, REG_STATUS, 32'h0000_0000);
    chk("inc status", q, 32'h0000_0007);
  endtask : t_inc
  // file subtract to both destinations, then literal subtract going negative
  task automatic t_sub;
    load();
    mem.fmem[12'h021] = 8'h03;
    mem.fmem[12'h022] = 8'h02;
    mem.prog[0] = fop(OPC_FILE_SUB, 1'b1, 1'b0, 8'h21);
    mem.prog[1] = fop(OPC_FILE_SUB, 1'b0, 1'b0, 8'h22);
    absolute_long_branch_at(2, 20'h0_0002);
    bus(1'b1, REG_ACC, 32'h0000_0002);
    run_prog(2, 1'b0, 1'b0);
    chk("fsub file", {24'h00_0000, mem.fmem[12'h021]}, 32'h0000_0001);
    bus(1'b0, REG_ACC, 32'h0000_0000);
    chk("fsub acc", q, 32'h0000_0000);
    bus(1'b0, REG_STATUS, 32'h0000_0000);
    chk("fsub status", q, 32'h0000_0007);
    load();
    mem.prog[0] = {OPC_LIT_SUB, 8'h02};
    absolute_long_branch_at(1, 20'h0_0001);
    bus(1'b1, REG_ACC, 32'h0000_0003);
    run_prog(1, 1'b0, 1'b0);
    bus(1'b0, REG_ACC, 32'h0000_0000);
    chk("lsub acc", q, 32'h0000_00FF);
    bus(1'b0, REG_STATUS, 32'h0000_0000);
    chk("lsub status", q, 32'h0000_0010);
  endtask : t_sub
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_skip();
    t_inc();
    t_sub();
    stop_test();
  end
endmodule : boe_exec_unit_tb
`default_nettype wire
